// ===== inc/sbs_pkg.sv
// shared constants and types for the burst-order and sleep controller
package sbs_pkg;
   // register map, byte addresses on the 32-bit register bus
   localparam logic [3:0] SBS_CFG_OFFS = 4'h0;
   localparam logic [3:0] SBS_STAT_OFFS = 4'h4;
   localparam int SBS_REG_AW = 4;
   // configuration fields and value after reset (interleaved, pipelined)
   localparam int SBS_CFG_ORDER_BIT = 0;
   localparam int SBS_CFG_PIPE_BIT = 1;
   localparam logic [1:0] SBS_CFG_RST = 2'h3;
   // status fields
   localparam int SBS_STAT_SLEEP_BIT = 0;
   localparam int SBS_STAT_WAKE_BIT = 1;
   localparam int SBS_STAT_CNT_LSB = 2;
   localparam int SBS_STAT_FULL_BIT = 4;
   localparam int SBS_STAT_EMPTY_BIT = 5;
   localparam int SBS_STAT_BURST_BIT = 6;
   // timing in clock cycles
   localparam int SBS_ENTRY_CYCLES = 2;
   localparam int SBS_WAKE_CYCLES = 2;
   localparam logic [1:0] SBS_WAKE_LAST = 2'(SBS_WAKE_CYCLES - 1);
   // buffering and array defaults
   localparam int SBS_FIFO_DEPTH = 32;
   localparam int SBS_DATA_W = 32;
   localparam int SBS_ADDR_W = 8;
   // bus responses
   localparam logic [1:0] SBS_RESP_OKAY = 2'h0;
   localparam logic [1:0] SBS_RESP_DECERR = 2'h3;
   // power state, one-hot
   typedef enum logic [2:0] {
      SBS_ST_ACTIVE = 3'h1,
      SBS_ST_SLEEP = 3'h2,
      SBS_ST_WAKE = 3'h4
   } sbs_pwr_t;
endpackage : sbs_pkg

// ===== inc/sbs_fifo_if.sv
// stream carrier between the controller and its write-posting buffer
`timescale 1ns/1ns
interface sbs_fifo_if #(parameter int W = 40);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   modport fifo (input in_valid, input in_data, input out_ready,
      output in_ready, output out_valid, output out_data);
   modport user (output in_valid, output in_data, output out_ready,
      input in_ready, input out_valid, input out_data);
endinterface : sbs_fifo_if

// ===== hw/sbs_fifo.sv
// synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sbs_fifo
   import sbs_pkg::*;
#(
   parameter int W = 40,
   parameter int DEPTH = SBS_FIFO_DEPTH
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // stream ports
   sbs_fifo_if.fifo f
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [PW:0] wr_ptr_r;
   logic [PW:0] rd_ptr_r;
   logic [PW:0] count_r;
   logic [PW:0] count_nxt;
   logic ready_r;
   logic push;
   logic pop;

   assign push = f.in_valid && ready_r;
   assign pop = f.out_valid && f.out_ready;
   assign count_nxt = count_r + (PW+1)'(push) - (PW+1)'(pop);
   assign f.in_ready = ready_r;
   assign f.out_valid = (count_r != '0);
   assign f.out_data = mem[rd_ptr_r[PW-1:0]];

   // storage is not reset, contents survive everything but a new write
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_r[PW-1:0]] <= f.in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         ready_r <= 1'b1;
      end
      else
      begin
         wr_ptr_r <= wr_ptr_r + (PW+1)'(push);
         rd_ptr_r <= rd_ptr_r + (PW+1)'(pop);
         count_r <= count_nxt;
         ready_r <= (count_nxt != (PW+1)'(DEPTH)); // honest full from a flop
      end
   end
endmodule : sbs_fifo

// ===== hw/sbs_ctrl.sv
// synchronous late-write SRAM core with burst sequencing and sleep control
//
// Behaviour
// - interleaved order: start XOR count 0..3
// - counter returns to start on fifth clock
// - undriven sleep request reads as low
// - sleep entered two cycles after request rises
// - array and pending writes kept while asleep
// - normal operation two cycles after request falls
// - asleep: deselected, inputs ignored, outputs high-z
// - sleep request is asynchronous, active high
// - mode bit picks flow-through or pipelined output
// - order select high interleaved, low linear
// - advance high steps counter, low loads address
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module sbs_ctrl
   import sbs_pkg::*;
#(
   parameter int ADDR_W = SBS_ADDR_W,
   parameter int DATA_W = SBS_DATA_W,
   parameter int FIFO_DEPTH = SBS_FIFO_DEPTH
)
(
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // sleep request, asynchronous
   input wire logic SLEEP_REQUEST,
   // memory command port
   input wire logic MEM_SELECT,
   input wire logic MEM_WRITE,
   input wire logic BURST_ADVANCE,
   input wire logic [ADDR_W-1:0] MEM_ADDR,
   output logic WRITE_READY,
   // two-way data pins
   input wire logic [DATA_W-1:0] DQ_IN,
   output logic [DATA_W-1:0] DQ_OUT,
   output logic DQ_OE_N,
   // register bus, write address and data
   input wire logic [SBS_REG_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // register bus, write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // register bus, read
   input wire logic [SBS_REG_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   localparam int FW = ADDR_W + DATA_W;

   // low two address bits of a burst step in either order
   function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] cnt,
      input logic interleave);
      burst_low = interleave ? (start ^ cnt) : 2'(start + cnt);
   endfunction : burst_low

   // register-bus address decode, used by both channels
   function automatic logic [1:0] reg_hit(input logic [SBS_REG_AW-1:0] a);
      reg_hit = {a == SBS_STAT_OFFS, a == SBS_CFG_OFFS};
   endfunction : reg_hit

   logic [DATA_W-1:0] mem [2**ADDR_W];
   sbs_fifo_if #(.W(FW)) wq ();

   logic zz_meta_r;
   logic zz_sync_r;
   sbs_pwr_t pwr_r;
   logic [1:0] wake_cnt_r;
   logic [1:0] cfg_r;
   logic [ADDR_W-1:0] base_r;
   logic [1:0] cnt_r;
   logic burst_r;
   logic [DATA_W-1:0] ft_data_r;
   logic ft_drive_r;
   logic [DATA_W-1:0] dq_out_r;
   logic dq_oe_n_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic [SBS_REG_AW-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic aw_have_r;
   logic w_have_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;

   logic listening;
   logic access;
   logic do_read;
   logic do_write;
   logic [1:0] cnt_nxt;
   logic [ADDR_W-1:0] acc_addr;
   logic [31:0] status;
   logic wr_go;
   logic [1:0] aw_hit;
   logic [1:0] ar_hit;

   // the write-posting buffer; its ready is the WRITE_READY pin
   sbs_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wq (
      .clk(CLK),
      .rst(SYS_RST),
      .f(wq)
   );

   // two-flop synchroniser for the asynchronous sleep request; a pad
   // pull-down keeps a floating pin low, and reset starts both flops low
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         zz_meta_r <= 1'b0;
         zz_sync_r <= 1'b0;
      end
      else
      begin
         zz_meta_r <= SLEEP_REQUEST;
         zz_sync_r <= zz_meta_r;
      end
   end

   // power state: sleep two edges after the request, wake two cycles after
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         pwr_r <= SBS_ST_ACTIVE;
         wake_cnt_r <= 2'h0;
      end
      else
      begin
         case (pwr_r)
            SBS_ST_ACTIVE:
            begin
               if (zz_sync_r)
               begin
                  pwr_r <= SBS_ST_SLEEP;
               end
            end
            SBS_ST_SLEEP:
            begin
               wake_cnt_r <= 2'h0;
               if (!zz_sync_r)
               begin
                  pwr_r <= SBS_ST_WAKE;
               end
            end
            SBS_ST_WAKE:
            begin
               wake_cnt_r <= wake_cnt_r + 2'h1;
               if (zz_sync_r)
               begin
                  pwr_r <= SBS_ST_SLEEP;
               end
               else if (wake_cnt_r == SBS_WAKE_LAST)
               begin
                  pwr_r <= SBS_ST_ACTIVE;
               end
            end
            default:
            begin
               pwr_r <= SBS_ST_ACTIVE;
            end
         endcase
      end
   end

   // command decode; asleep every memory-port input is ignored, the register bus still answers
   assign listening = (pwr_r != SBS_ST_SLEEP);
   assign access = listening && (BURST_ADVANCE ? burst_r : MEM_SELECT);
   assign do_read = access && !MEM_WRITE;
   // writes in recovery are dropped; the controller may only read then
   assign do_write = access && MEM_WRITE && (pwr_r == SBS_ST_ACTIVE);
   assign cnt_nxt = cnt_r + 2'h1;
   // on advance, high bits from the loaded base, counter only on bits 1:0; otherwise MEM_ADDR
   assign acc_addr = BURST_ADVANCE ?
      {base_r[ADDR_W-1:2], burst_low(base_r[1:0], cnt_nxt, cfg_r[SBS_CFG_ORDER_BIT])} :
      MEM_ADDR;

   // burst counter: load on advance low, step on advance high
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         base_r <= '0;
         cnt_r <= 2'h0;
         burst_r <= 1'b0;
      end
      else if (listening)
      begin
         if (!BURST_ADVANCE)
         begin
            base_r <= MEM_ADDR;
            cnt_r <= 2'h0;
            burst_r <= MEM_SELECT;
         end
         else if (burst_r)
         begin
            cnt_r <= cnt_nxt;
         end
      end
   end

   // writes are posted; the buffer drains to the array when the
   // array port is free, and holds its contents while asleep
   assign wq.in_valid = do_write;
   assign wq.in_data = {acc_addr, DQ_IN};
   assign wq.out_ready = (pwr_r == SBS_ST_ACTIVE) && !do_read;
   assign WRITE_READY = wq.in_ready;

   // array write port, never reset so contents survive sleep
   always_ff @(posedge CLK)
   begin
      if (wq.out_valid && wq.out_ready)
      begin
         mem[wq.out_data[FW-1:DATA_W]] <= wq.out_data[DATA_W-1:0];
      end
   end

   // first output stage: the flow-through register
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         ft_data_r <= '0;
         ft_drive_r <= 1'b0;
      end
      else
      begin
         ft_data_r <= do_read ? mem[acc_addr] : ft_data_r;
         ft_drive_r <= do_read;
      end
   end

   // pins: flow-through takes stage one, pipelined adds a stage;
   // entering sleep from active forces the drivers off at once; from recovery, one edge later
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         dq_out_r <= '0;
         dq_oe_n_r <= 1'b1;
      end
      else if (!listening || (zz_sync_r && pwr_r == SBS_ST_ACTIVE))
      begin
         dq_oe_n_r <= 1'b1;
      end
      else if (!cfg_r[SBS_CFG_PIPE_BIT])
      begin
         dq_out_r <= do_read ? mem[acc_addr] : dq_out_r;
         dq_oe_n_r <= !do_read;
      end
      else
      begin
         dq_out_r <= ft_data_r;
         dq_oe_n_r <= !ft_drive_r;
      end
   end

   assign DQ_OUT = dq_out_r;
   assign DQ_OE_N = dq_oe_n_r;

   // status word seen by software
   always_comb
   begin
      status = '0;
      status[SBS_STAT_SLEEP_BIT] = (pwr_r == SBS_ST_SLEEP);
      status[SBS_STAT_WAKE_BIT] = (pwr_r == SBS_ST_WAKE);
      status[SBS_STAT_CNT_LSB +: 2] = cnt_r;
      status[SBS_STAT_FULL_BIT] = !wq.in_ready;
      status[SBS_STAT_EMPTY_BIT] = !wq.out_valid;
      status[SBS_STAT_BURST_BIT] = burst_r;
   end

   // register write channel: address and data taken in either order
   assign wr_go = aw_have_r && w_have_r && !bvalid_r;
   assign aw_hit = reg_hit(awaddr_r);
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= SBS_RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && awready_r)
         begin
            awaddr_r <= S_AXI_AWADDR;
            aw_have_r <= 1'b1;
            awready_r <= 1'b0;
         end
         if (S_AXI_WVALID && wready_r)
         begin
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
            w_have_r <= 1'b1;
            wready_r <= 1'b0;
         end
         if (wr_go)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= (aw_hit != 2'h0) ? SBS_RESP_OKAY : SBS_RESP_DECERR;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
         end
         if (bvalid_r && S_AXI_BREADY)
         begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // configuration register; status is read-only and ignores writes
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         cfg_r <= SBS_CFG_RST;
      end
      else if (wr_go && aw_hit[0] && wstrb_r[0])
      begin
         cfg_r <= wdata_r[1:0];
      end
   end

   // register read channel, one read at a time
   assign ar_hit = reg_hit(S_AXI_ARADDR);
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rresp_r <= SBS_RESP_OKAY;
         rdata_r <= '0;
      end
      else if (S_AXI_ARVALID && arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rresp_r <= (ar_hit != 2'h0) ? SBS_RESP_OKAY : SBS_RESP_DECERR;
         rdata_r <= ar_hit[0] ? {30'h0, cfg_r} : (ar_hit[1] ? status : 32'h0);
      end
      else if (rvalid_r && S_AXI_RREADY)
      begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   assign S_AXI_AWREADY = awready_r;
   assign S_AXI_WREADY = wready_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_ARREADY = arready_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RRESP = rresp_r;
   assign S_AXI_RDATA = rdata_r;
endmodule : sbs_ctrl

// ===== dv/sbs_ctrl_asserts.sv
// port checker for the burst-order and sleep controller
`timescale 1ns/1ns
module sbs_ctrl_asserts
   import sbs_pkg::*;
(
   // clock, reset, sleep
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic SLEEP_REQUEST,
   // memory port
   input wire logic MEM_SELECT,
   input wire logic MEM_WRITE,
   input wire logic BURST_ADVANCE,
   input wire logic DQ_OE_N,
   // register bus
   input wire logic [SBS_REG_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   logic [2:0] quiet_r;
   logic [3:0] aw_a_r;
   logic [1:0] wd_r;
   logic ws_r;
   logic [1:0] cfg_r;
   wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
   wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
   wire rd_load = MEM_SELECT && !MEM_WRITE && !BURST_ADVANCE && quiet_r > 3'h4;
   wire rd_any = !MEM_WRITE && (MEM_SELECT || BURST_ADVANCE);
   // cycles since sleep was last requested; reads only judged once fully awake
   always_ff @(posedge CLK)
      if (SYS_RST)
         quiet_r <= 3'h7;
      else if (SLEEP_REQUEST)
         quiet_r <= 3'h0;
      else if (quiet_r != 3'h7)
         quiet_r <= quiet_r + 3'h1;
   // shadow of the output-mode field, applied when the write completes
   always_ff @(posedge CLK)
   begin
      if (aw_hs)
         aw_a_r <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         wd_r <= S_AXI_WDATA[1:0];
         ws_r <= S_AXI_WSTRB[0]; // byte lane 0 carries the whole field
      end
      if (SYS_RST)
         cfg_r <= SBS_CFG_RST;
      else if (S_AXI_BVALID && S_AXI_BREADY && aw_a_r == SBS_CFG_OFFS && ws_r)
         cfg_r <= wd_r;
   end
   sequence s_asleep;
      SLEEP_REQUEST [*3];
   endsequence
   sequence s_both_taken;
      aw_hs && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   property p_sleep_hiz;
      s_asleep |=> DQ_OE_N;
   endproperty
   property p_ft_read;
      rd_load && !cfg_r[SBS_CFG_PIPE_BIT] |=> !DQ_OE_N;
   endproperty
   property p_pipe_read;
      rd_load && cfg_r[SBS_CFG_PIPE_BIT] |-> ##2 !DQ_OE_N;
   endproperty
   property p_oe_cause;
      !DQ_OE_N |-> $past(rd_any) || $past(rd_any, 2);
   endproperty
   property p_b_time;
      s_both_taken |-> ##[1:2] S_AXI_BVALID;
   endproperty
   property p_r_time;
      ar_hs |=> S_AXI_RVALID;
   endproperty
   property p_aw_busy;
      aw_hs |=> !S_AXI_AWREADY;
   endproperty
   property p_ar_busy;
      ar_hs |=> !S_AXI_ARREADY;
   endproperty
   a_sleep_hiz: assert property (p_sleep_hiz)
      else $error("data pins driven while asleep");
   a_ft_read: assert property (p_ft_read)
      else $error("flow-through read late");
   a_pipe_read: assert property (p_pipe_read)
      else $error("pipelined read late");
   a_oe_cause: assert property (p_oe_cause)
      else $error("data pins driven with no read");
   a_b_time: assert property (p_b_time)
      else $error("write response missing");
   a_r_time: assert property (p_r_time)
      else $error("read response missing");
   a_aw_busy: assert property (p_aw_busy)
      else $error("write address ready too early");
   a_ar_busy: assert property (p_ar_busy)
      else $error("read address ready too early");
endmodule : sbs_ctrl_asserts
bind sbs_ctrl sbs_ctrl_asserts sbs_ctrl_asserts_inst (.CLK(CLK), .SYS_RST(SYS_RST),
   .SLEEP_REQUEST(SLEEP_REQUEST), .MEM_SELECT(MEM_SELECT), .MEM_WRITE(MEM_WRITE),
   .BURST_ADVANCE(BURST_ADVANCE), .DQ_OE_N(DQ_OE_N), .S_AXI_AWADDR(S_AXI_AWADDR),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
   .S_AXI_WSTRB(S_AXI_WSTRB),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID));

// ===== dv/sbs_mem_host.sv
// memory-controller model driving the command and data pins
`timescale 1ns/1ns
module sbs_mem_host
(
   // clock
   input wire logic clk,
   // commands toward the block
   output logic sel,
   output logic wr,
   output logic burst_advance,
   output logic [7:0] addr,
   output logic [31:0] dq,
   output logic sleep_on,
   // answers
   input wire logic wr_rdy,
   input wire logic [31:0] dq_out,
   input wire logic dq_oe_n
);
   logic [31:0] rdq[$];
   initial
   begin
      {sel, wr, burst_advance, sleep_on} = 4'h0;
      {addr, dq} = 40'h00_0000_0000;
   end
   // every driven word is kept; its latency is the checker's business
   always @(posedge clk)
      if (!dq_oe_n)
         rdq.push_back(dq_out);
   // one command per cycle; an idle data bus toggles so it never looks valid
   task cmd(input logic s, input logic w, input logic a, input logic [7:0] ad,
         input logic [31:0] d);
      @(posedge clk);
      while (w && !wr_rdy)
         @(posedge clk);
      sel <= s;
      wr <= w;
      burst_advance <= a;
      addr <= ad;
      dq <= w ? d : ~dq;
   endtask : cmd
   task idle(input int n);
      repeat (n) cmd(1'b0, 1'b0, 1'b0, addr, dq);
   endtask : idle
   // drain before sleeping, and only deselects while recovering
   task sleep(input logic on);
      if (on)
         idle(40);
      @(posedge clk);
      sleep_on <= on;
      if (!on)
         idle(3);
   endtask : sleep
endmodule : sbs_mem_host

// ===== dv/sbs_ctrl_tb_top.sv
// self-checking bench for the burst-order and sleep controller
`timescale 1ns/1ns
module sbs_ctrl_tb_top
   import sbs_pkg::*;
;
   logic clk, sys_rst, mem_sel, mem_wr, mem_adv, host_sleep, wr_rdy, oe_n;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [3:0] awaddr, araddr, wstrb;
   logic [1:0] bresp, rresp, r;
   logic [7:0] mem_addr, a, x;
   logic [31:0] wdata, rdata, host_dq, dq_in, dq_out, d, key;
   int errors = 0;
   int check_count = 0;
   tri0 sleep_w;
   // pad pull-down: released request reads low
   assign sleep_w = host_sleep ? 1'b1 : 1'bz;
   // shared data wire: the device wins while it drives
   assign dq_in = oe_n ? host_dq : dq_out;
   sbs_ctrl sbs_ctrl_inst (.CLK(clk), .SYS_RST(sys_rst), .SLEEP_REQUEST(sleep_w),
      .MEM_SELECT(mem_sel), .MEM_WRITE(mem_wr), .BURST_ADVANCE(mem_adv), .MEM_ADDR(mem_addr),
      .WRITE_READY(wr_rdy), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_N(oe_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   sbs_mem_host sbs_mem_host_inst (.clk(clk), .sel(mem_sel), .wr(mem_wr), .burst_advance(mem_adv),
      .addr(mem_addr), .dq(host_dq), .sleep_on(host_sleep), .wr_rdy(wr_rdy),
      .dq_out(dq_in), .dq_oe_n(oe_n));
   function automatic logic [7:0] baddr(input logic [7:0] s, input int k, input logic il);
      baddr = {s[7:2], il ? s[1:0] ^ 2'(k) : s[1:0] + 2'(k)};
   endfunction : baddr
   function automatic logic [31:0] word(input logic [7:0] s);
      word = key ^ {24'h00_0000, s};
   endfunction : word
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // address and data offered together, each dropped as soon as it is taken
   task axi_wr(input logic [3:0] ad, input logic [31:0] v, input logic [3:0] st,
         output logic [1:0] rs);
      @(posedge clk);
      awaddr <= ad;
      wdata <= v;
      wstrb <= st;
      {awvalid, wvalid, bready} <= 3'h7;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task axi_rd(input logic [3:0] ad, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      araddr <= ad;
      {arvalid, rready} <= 2'h3;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      {v, rs} = {rdata, rresp};
      rready <= 1'b0;
   endtask : axi_rd
   task end_sim();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // a hang costs at most this many cycles
   initial
   begin
      #(40 * 20000);
      errors++;
      end_sim();
   end
   initial
   begin
      void'($urandom(32'h0000_602d));
      {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0000_0000, 4'hf};
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      key = $urandom;
      // reset values, unmapped places and the read-only status word
      axi_rd(SBS_CFG_OFFS, d, r);
      check("cfg reset", d, 32'(SBS_CFG_RST));
      axi_rd(SBS_STAT_OFFS, d, r);
      check("status reset", d & 32'h0000_0023, 32'h0000_0020);
      axi_wr(4'h8, 32'hffff_ffff, 4'hf, r);
      check("unmapped write", 32'(r), 32'(SBS_RESP_DECERR));
      axi_rd(4'hc, d, r);
      check("unmapped read", {d[29:0], r}, 32'(SBS_RESP_DECERR));
      axi_wr(SBS_STAT_OFFS, 32'h0000_0003, 4'h1, r);
      check("status write", 32'(r), 32'(SBS_RESP_OKAY));
      // lane 0 off: the mode field must keep its value, and status writes left it alone
      axi_wr(SBS_CFG_OFFS, 32'h0000_0000, 4'he, r);
      axi_rd(SBS_CFG_OFFS, d, r);
      check("cfg kept", d, 32'(SBS_CFG_RST));
      // every order and output mode: five-beat read bursts over a written block
      for (int m = 0; m < 4; m++)
      begin
         axi_wr(SBS_CFG_OFFS, 32'(m), 4'($urandom) | 4'h1, r);
         a = (m == 0) ? 8'hfe : 8'($urandom);
         for (int i = -1; i < 5; i++)
         begin
            x = {a[7:2], 2'h0} + 8'(i);
            sbs_mem_host_inst.cmd(1'b1, 1'b1, 1'b0, x, word(x));
         end
         sbs_mem_host_inst.idle(40);
         sbs_mem_host_inst.rdq.delete();
         sbs_mem_host_inst.cmd(1'b1, 1'b0, 1'b0, a, 32'h0000_0000);
         repeat (4) sbs_mem_host_inst.cmd(1'b0, 1'b0, 1'b1, a, 32'h0000_0000);
         sbs_mem_host_inst.idle(4);
         check("burst beats", 32'(sbs_mem_host_inst.rdq.size()), 32'h0000_0005);
         for (int k = 0; k < 5; k++)
            check("burst word", sbs_mem_host_inst.rdq[k], word(baddr(a, k, m[0])));
      end
      // sleep keeps the array and ignores commands
      a = 8'($urandom);
      sbs_mem_host_inst.cmd(1'b1, 1'b1, 1'b0, a, ~word(a));
      sbs_mem_host_inst.sleep(1'b1);
      repeat (3) @(posedge clk);
      axi_rd(SBS_STAT_OFFS, d, r);
      check("asleep flag", 32'(d[SBS_STAT_SLEEP_BIT]), 32'h0000_0001);
      sbs_mem_host_inst.rdq.delete();
      sbs_mem_host_inst.cmd(1'b1, 1'b0, 1'b0, a, 32'h0000_0000);
      sbs_mem_host_inst.idle(4);
      check("read while asleep", 32'(sbs_mem_host_inst.rdq.size()), 32'h0000_0000);
      sbs_mem_host_inst.sleep(1'b0);
      sbs_mem_host_inst.idle(2);
      sbs_mem_host_inst.cmd(1'b1, 1'b0, 1'b0, a, 32'h0000_0000);
      sbs_mem_host_inst.idle(4);
      check("kept word", sbs_mem_host_inst.rdq[0], ~word(a));
      axi_rd(SBS_STAT_OFFS, d, r);
      check("awake flags", d & 32'h0000_0003, 32'h0000_0000);
      end_sim();
   end
endmodule : sbs_ctrl_tb_top
